/* core/isoci_pkg.sv */
// Package for the isochronous context interrupt registers.
// Assumes an APB slave port with 32-bit data and byte addresses.
package isoci_pkg;
    localparam int CTX_N = 8;
    localparam int ADDR_W = 8;
    // Byte offsets of the set and clear ports
    localparam logic [ADDR_W-1:0] TX_EV_SET_OFS = 8'h90;
    localparam logic [ADDR_W-1:0] TX_EV_CLR_OFS = 8'h94;
    localparam logic [ADDR_W-1:0] TX_EN_SET_OFS = 8'h98;
    localparam logic [ADDR_W-1:0] TX_EN_CLR_OFS = 8'h9C;
    localparam logic [ADDR_W-1:0] RX_EV_SET_OFS = 8'hA0;
    localparam logic [ADDR_W-1:0] RX_EV_CLR_OFS = 8'hA4;
    localparam logic [ADDR_W-1:0] RX_EN_SET_OFS = 8'hA8;
    localparam logic [ADDR_W-1:0] RX_EN_CLR_OFS = 8'hAC;
    // Values after reset
    localparam logic [CTX_N-1:0] EVENT_RST = 8'h00;
    localparam logic [CTX_N-1:0] ENABLE_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h00000000;
    localparam logic [31-CTX_N:0] RSVD_ZERO = 24'h000000;

    typedef enum {
        ISOCI_NONE, ISOCI_TX_EV_SET, ISOCI_TX_EV_CLR, ISOCI_TX_EN_SET,
        ISOCI_TX_EN_CLR, ISOCI_RX_EV_SET, ISOCI_RX_EV_CLR, ISOCI_RX_EN_SET,
        ISOCI_RX_EN_CLR
    } isoci_reg_type;

    // Descriptor completion report from the contexts, one bit per context
    typedef struct packed {
        logic [CTX_N-1:0] done;
        logic [CTX_N-1:0] kind;
        logic [CTX_N-1:0] irq;
    } isoci_cmd_type;

    typedef struct packed {
        logic [CTX_N-1:0] tx_context_events;
        logic [CTX_N-1:0] tx_context_enables;
        logic [CTX_N-1:0] rx_context_events;
        logic [CTX_N-1:0] rx_context_enables;
        logic [CTX_N-1:0] tx_context_flags;
        logic [CTX_N-1:0] tx_flags_prev;
        logic [CTX_N-1:0] rx_context_flags;
        logic [CTX_N-1:0] rx_flags_prev;
        logic tx_summary_event;
        logic rx_summary_event;
        logic irq_request;
        logic [31:0] prdata;
    } isoci_state_type;
endpackage

/* core/isoci_regs.sv */
// Per-context event and enable registers for eight transmit and eight
// receive isochronous contexts, with the two summary events.
// Assumes APB on pclk; context reports come from logic on pclk.
//
// Function
// - Transmit context pulses when its final-output command completes requesting interrupt.
// - Event bit sets on rising edge of context pulse or set-port write one.
// - Event bit clears only by writing one at the clear port.
// - Transmit event set port reads the raw transmit events.
// - Transmit event clear port reads transmit events AND transmit enables.
// - Both transmit enable ports read the transmit enables.
// - Transmit enable bit lets its event reach the interrupt, else blocks it.
// - Bits 31 to 8 of all these registers read zero.
// - Transmit event bit n marks context n behind summary bit 6.
// - Receive context pulses when any input command completes requesting interrupt.
// - Receive event bit n marks context n behind summary bit 7.
// - Receive enables AND receive events; only both-set bits interrupt.
// - Receive event set port reads the raw receive events.
// - Receive event clear port reads receive events AND receive enables.
// - Both receive enable ports read the receive enables.
// - Receive enable bit enables its event as source, else disables it.
// - Host mask bits 7 and 6 let the summaries raise the processor interrupt.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module isoci_regs
    import isoci_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Completion reports; kind is output-last for tx, input for rx
    input wire isoci_cmd_type tx_cmd,
    input wire isoci_cmd_type rx_cmd,
    // Host interrupt mask bits 6 and 7
    input wire logic host_mask_tx,
    input wire logic host_mask_rx,
    // Host event register sources
    output logic tx_summary_event,
    output logic rx_summary_event,
    output logic irq_request,
    output logic [CTX_N-1:0] tx_context_flags,
    output logic [CTX_N-1:0] rx_context_flags
);

    function automatic isoci_reg_type reg_decode(input logic [ADDR_W-1:0] a);
        unique case (a)
            TX_EV_SET_OFS: reg_decode = ISOCI_TX_EV_SET;
            TX_EV_CLR_OFS: reg_decode = ISOCI_TX_EV_CLR;
            TX_EN_SET_OFS: reg_decode = ISOCI_TX_EN_SET;
            TX_EN_CLR_OFS: reg_decode = ISOCI_TX_EN_CLR;
            RX_EV_SET_OFS: reg_decode = ISOCI_RX_EV_SET;
            RX_EV_CLR_OFS: reg_decode = ISOCI_RX_EV_CLR;
            RX_EN_SET_OFS: reg_decode = ISOCI_RX_EN_SET;
            RX_EN_CLR_OFS: reg_decode = ISOCI_RX_EN_CLR;
            default: reg_decode = ISOCI_NONE;
        endcase
    endfunction

    isoci_state_type s_q;
    isoci_state_type s_d;
    isoci_reg_type wsel;
    isoci_reg_type rsel;
    logic wr_acc;
    logic rd_setup;
    logic [CTX_N-1:0] wbits;
    logic [CTX_N-1:0] tx_req;
    logic [CTX_N-1:0] rx_req;
    logic [CTX_N-1:0] tx_rise;
    logic [CTX_N-1:0] rx_rise;
    logic [CTX_N-1:0] tx_masked;
    logic [CTX_N-1:0] rx_masked;
    logic [CTX_N-1:0] tx_clr;
    logic [CTX_N-1:0] rx_clr;

    // Registers answer at once; no wait states
    assign pready = 1'b1;
    assign wsel = reg_decode(paddr);
    assign rsel = wsel;
    assign pslverr = psel & penable & (wsel == ISOCI_NONE);
    assign wr_acc = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    // Only the low lane holds defined bits; other lanes are ignored
    assign wbits = pstrb[0] ? pwdata[CTX_N-1:0] : '0;

    assign tx_masked = s_q.tx_context_events & s_q.tx_context_enables;
    assign rx_masked = s_q.rx_context_events & s_q.rx_context_enables;
    assign tx_clr = (wr_acc && wsel == ISOCI_TX_EV_CLR) ? wbits : '0;
    assign rx_clr = (wr_acc && wsel == ISOCI_RX_EV_CLR) ? wbits : '0;

    // Per-context pulse forming, qualified by command kind and interrupt bits
    for (genvar i = 0; i < CTX_N; i++) begin : g_ctx
        assign tx_req[i] = tx_cmd.done[i] & tx_cmd.kind[i] & tx_cmd.irq[i];
        assign rx_req[i] = rx_cmd.done[i] & rx_cmd.kind[i] & rx_cmd.irq[i];
        assign tx_rise[i] = s_q.tx_context_flags[i] & ~s_q.tx_flags_prev[i];
        assign rx_rise[i] = s_q.rx_context_flags[i] & ~s_q.rx_flags_prev[i];
    end

    always_comb begin
        s_d = s_q;
        s_d.tx_context_flags = tx_req;
        s_d.rx_context_flags = rx_req;
        s_d.tx_flags_prev = s_q.tx_context_flags;
        s_d.rx_flags_prev = s_q.rx_context_flags;
        // Set beats clear so an edge during a clear write is kept
        s_d.tx_context_events = (s_q.tx_context_events & ~tx_clr) | tx_rise;
        s_d.rx_context_events = (s_q.rx_context_events & ~rx_clr) | rx_rise;
        if (wr_acc) begin
            unique case (wsel)
                ISOCI_TX_EV_SET: s_d.tx_context_events = s_d.tx_context_events | wbits;
                ISOCI_RX_EV_SET: s_d.rx_context_events = s_d.rx_context_events | wbits;
                ISOCI_TX_EN_SET: s_d.tx_context_enables = s_q.tx_context_enables | wbits;
                ISOCI_TX_EN_CLR: s_d.tx_context_enables = s_q.tx_context_enables & ~wbits;
                ISOCI_RX_EN_SET: s_d.rx_context_enables = s_q.rx_context_enables | wbits;
                ISOCI_RX_EN_CLR: s_d.rx_context_enables = s_q.rx_context_enables & ~wbits;
                default: ;
            endcase
        end
        // Summaries lag the event bits by one cycle, traded for a flop output
        s_d.tx_summary_event = |tx_masked;
        s_d.rx_summary_event = |rx_masked;
        s_d.irq_request = (s_d.tx_summary_event & host_mask_tx)
                        | (s_d.rx_summary_event & host_mask_rx);
        // Read data captured in setup so it stands through the access phase
        if (rd_setup) begin
            unique case (rsel)
                ISOCI_TX_EV_SET: s_d.prdata = {RSVD_ZERO, s_q.tx_context_events};
                ISOCI_TX_EV_CLR: s_d.prdata = {RSVD_ZERO, tx_masked};
                ISOCI_TX_EN_SET,
                ISOCI_TX_EN_CLR: s_d.prdata = {RSVD_ZERO, s_q.tx_context_enables};
                ISOCI_RX_EV_SET: s_d.prdata = {RSVD_ZERO, s_q.rx_context_events};
                ISOCI_RX_EV_CLR: s_d.prdata = {RSVD_ZERO, rx_masked};
                ISOCI_RX_EN_SET,
                ISOCI_RX_EN_CLR: s_d.prdata = {RSVD_ZERO, s_q.rx_context_enables};
                default: s_d.prdata = RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{
                tx_context_events: EVENT_RST, tx_context_enables: ENABLE_RST,
                rx_context_events: EVENT_RST, rx_context_enables: ENABLE_RST,
                tx_context_flags: EVENT_RST, tx_flags_prev: EVENT_RST,
                rx_context_flags: EVENT_RST, rx_flags_prev: EVENT_RST,
                tx_summary_event: 1'b0, rx_summary_event: 1'b0,
                irq_request: 1'b0, prdata: RDATA_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign tx_summary_event = s_q.tx_summary_event;
    assign rx_summary_event = s_q.rx_summary_event;
    assign irq_request = s_q.irq_request;
    assign tx_context_flags = s_q.tx_context_flags;
    assign rx_context_flags = s_q.rx_context_flags;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_tx_pulse;
        (tx_req != '0) |=> (s_q.tx_context_flags == $past(tx_req));
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx pulse missing");

    property p_rx_pulse;
        (rx_req != '0) |=> (s_q.rx_context_flags == $past(rx_req));
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse missing");

    property p_edge_sets;
        (tx_req != '0) ##1 (tx_rise != '0)
            |=> ((s_q.tx_context_events & $past(tx_rise)) == $past(tx_rise));
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge lost");

    property p_clear_only;
        ((s_q.tx_context_events & ~s_d.tx_context_events) & ~tx_clr) == '0;
    endproperty
    a_clear_only: assert property (p_clear_only) else $error("tx event cleared");

    property p_rd_txc;
        (rd_setup && paddr == TX_EV_CLR_OFS)
            |=> (prdata == {RSVD_ZERO, $past(tx_masked)});
    endproperty
    a_rd_txc: assert property (p_rd_txc) else $error("tx masked read");

    property p_rd_rxs;
        (rd_setup && paddr == RX_EV_SET_OFS)
            |=> (prdata[CTX_N-1:0] == $past(s_q.rx_context_events));
    endproperty
    a_rd_rxs: assert property (p_rd_rxs) else $error("rx event read");

    property p_rsvd;
        (psel && penable && !pwrite) |-> (prdata[31:CTX_N] == RSVD_ZERO);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

    property p_sum;
        ##1 (tx_summary_event == $past(|tx_masked))
            && (rx_summary_event == $past(|rx_masked));
    endproperty
    a_sum: assert property (p_sum) else $error("summary wrong");

    property p_irq;
        irq_request == ((tx_summary_event & $past(host_mask_tx))
                      | (rx_summary_event & $past(host_mask_rx)));
    endproperty
    a_irq: assert property (p_irq) else $error("irq wrong");

    property p_en_set;
        (wr_acc && paddr == TX_EN_SET_OFS)
            |=> ((s_q.tx_context_enables & $past(wbits)) == $past(wbits));
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable not set");

endmodule

/* test/isoci_ctx_model.sv */
// Model of the sixteen isochronous contexts reporting completed commands.
// Assumes the bench calls complete() right after a rising pclk edge.
`timescale 1ns/100ps
module isoci_ctx_model
    import isoci_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Completion reports
    output isoci_cmd_type tx_cmd,
    output isoci_cmd_type rx_cmd
);
    initial begin
        tx_cmd = '0;
        rx_cmd = '0;
    end
    // One-cycle report, so each call is one fresh edge for the device
    task automatic complete(input logic rx, input logic [7:0] ctx, input logic k, input logic i);
        isoci_cmd_type c;
        c.done = ctx;
        c.kind = {8{k}};
        c.irq = {8{i}};
        @(posedge pclk);
        if (rx) rx_cmd <= c;
        else tx_cmd <= c;
        @(posedge pclk);
        tx_cmd <= '0;
        rx_cmd <= '0;
    endtask
endmodule

/* test/isoci_regs_bench.sv */
// Self-checking bench for the isochronous context interrupt registers.
// Assumes a zero-wait APB slave and the context model beside it.
`timescale 1ns/100ps
module isoci_regs_bench
    import isoci_pkg::*;
;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} isoci_row_type;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err_seen;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, host_mask_tx = 1, host_mask_rx = 1, tx_sum, rx_sum, irq;
    logic [7:0] tx_fl, rx_fl;
    isoci_cmd_type tx_cmd, rx_cmd;
    int errors = 0, samples_checked = 0;
    isoci_row_type rows [18] = '{
        '{1, TX_EN_SET_OFS, 32'hFFFFFF0F}, '{0, TX_EN_CLR_OFS, 32'h0F},
        '{1, TX_EV_SET_OFS, 32'h33}, '{0, TX_EV_SET_OFS, 32'h33}, '{0, TX_EV_CLR_OFS, 32'h03},
        '{1, TX_EN_CLR_OFS, 32'h01}, '{0, TX_EN_SET_OFS, 32'h0E},
        '{1, TX_EV_CLR_OFS, 32'h11}, '{0, TX_EV_SET_OFS, 32'h22},
        '{1, RX_EN_SET_OFS, 32'hF0}, '{1, RX_EV_SET_OFS, 32'h3C}, '{0, RX_EV_SET_OFS, 32'h3C},
        '{0, RX_EV_CLR_OFS, 32'h30}, '{0, RX_EN_CLR_OFS, 32'hF0}, '{1, RX_EN_CLR_OFS, 32'h10},
        '{1, RX_EV_CLR_OFS, 32'h3C}, '{0, RX_EN_SET_OFS, 32'hE0}, '{0, RX_EV_SET_OFS, 32'h00}};

    initial forever #50 pclk = ~pclk;

    isoci_ctx_model i_isoci_ctx_model (.pclk(pclk), .presetn(presetn), .tx_cmd(tx_cmd),
        .rx_cmd(rx_cmd));
    isoci_regs i_isoci_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_cmd(tx_cmd), .rx_cmd(rx_cmd),
        .host_mask_tx(host_mask_tx), .host_mask_rx(host_mask_rx), .tx_summary_event(tx_sum),
        .rx_summary_event(rx_sum), .irq_request(irq), .tx_context_flags(tx_fl),
        .rx_context_flags(rx_fl));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err_seen = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge pclk);
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (int k = 0; k < 8; k++) begin
            apb(0, TX_EV_SET_OFS + 8'(4 * k), '0);
            check(r, 32'h0);
        end
        $display("reset values done");
        // Upper ones in the first row must never read back
        foreach (rows[k]) begin
            apb(rows[k].wr, rows[k].a, rows[k].d);
            if (!rows[k].wr) check(r, rows[k].d);
        end
        $display("register table done");
        repeat (3) @(posedge pclk);
        check({tx_sum, rx_sum, irq}, 3'b101);
        host_mask_tx <= 0;
        repeat (2) @(posedge pclk);
        check(irq, 1'b0);
        apb(1, TX_EN_CLR_OFS, 32'h0E);
        repeat (3) @(posedge pclk);
        check(tx_sum, 1'b0);
        apb(0, 8'hB0, '0);
        check(r, 32'h0);
        check(err_seen, 1'b1);
        check(pready, 1'b1);
        pstrb <= 4'hE;
        apb(1, TX_EV_SET_OFS, 32'h01);
        pstrb <= 4'hF;
        apb(0, TX_EV_SET_OFS, '0);
        check(r, 32'h22);
        $display("masking and refusals done");
        i_isoci_ctx_model.complete(0, 8'h40, 1, 1);
        #1 check(tx_fl, 32'h40);
        i_isoci_ctx_model.complete(0, 8'h80, 0, 1);
        apb(0, TX_EV_SET_OFS, '0);
        check(r, 32'h62);
        // Edge and clear-port write land on the same edge
        fork
            i_isoci_ctx_model.complete(0, 8'h02, 1, 1);
            apb(1, TX_EV_CLR_OFS, 32'h02);
        join
        apb(0, TX_EV_SET_OFS, '0);
        check(r, 32'h62);
        i_isoci_ctx_model.complete(1, 8'h04, 1, 0);
        i_isoci_ctx_model.complete(1, 8'h08, 1, 1);
        #1 check(rx_fl, 32'h08);
        apb(1, RX_EN_SET_OFS, 32'h08);
        repeat (3) @(posedge pclk);
        check({rx_sum, irq}, 2'b11);
        apb(0, RX_EV_CLR_OFS, '0);
        check(r, 32'h08);
        apb(1, RX_EN_CLR_OFS, 32'h08);
        repeat (3) @(posedge pclk);
        check({rx_sum, irq}, 2'b00);
        $display("context events done");
        report_and_stop();
    end
endmodule
